// File: rtl/fim_pkg.sv
// Purpose: shared constants and types for the memory map and flash info-read block
// Assumes: byte-wide special-function space, 16-bit flash address pair
// Notes: flash program/erase command codes are local encodings
package fim_pkg;
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [7:0] SFR_DPL = 8'h82;
    localparam logic [7:0] SFR_DPH = 8'h83;
    localparam logic [7:0] SFR_SEC_IDX = 8'h96;
    localparam logic [7:0] SFR_SEC_WIN = 8'h97;
    localparam logic [7:0] SFR_PXH = 8'hA0;
    localparam logic [7:0] SFR_FADDR_H = 8'hCE;
    localparam logic [7:0] SFR_FADDR_L = 8'hCF;
    localparam logic [7:0] SFR_FWDATA = 8'hD1;
    localparam logic [7:0] SFR_FCMD = 8'hD2;
    localparam logic [7:0] SFR_FTIME = 8'hD3;
    localparam logic [7:0] SFR_FRDATA = 8'hD4;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PXH = 8'hFF;
    localparam logic [7:0] RST_FTIME = 8'hDD;
    localparam logic [7:0] RST_CAUSE_POR = 8'h02;
    localparam logic [7:0] CFG_WORD_RST = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] CMD_IDLE = 8'h00;
    localparam logic [7:0] CMD_INFO_RD = 8'h88;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h51;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] CMD_BYTE_WRITE = 8'h53;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] SEC_CFG_LAST = 8'h0D;
    localparam logic [7:0] SEC_RST_CAUSE = 8'h0F;
    localparam logic [15:0] XRAM_LAST = 16'h0FFF;
    localparam logic [15:0] DISP_BASE = 16'h1000;
    localparam logic [15:0] DISP_LAST = 16'h101B;
    localparam int DISP_LEN = 28;
    localparam int XRAM_LEN = 4096;
    localparam logic [15:0] UID_BASE = 16'h41A8;
    localparam logic [15:0] UID_LAST = 16'h41AF;
    localparam logic [15:0] CODE_LAST = 16'hFBFF;
    localparam logic [15:0] BOOT_2K = 16'h0800;
    localparam logic [15:0] BOOT_4K = 16'h1000;
    localparam logic [15:0] BOOT_8K = 16'h2000;

    typedef enum logic [1:0] {k_direct, k_indirect, k_regn, k_bit} fim_kind_t;
    typedef enum logic [1:0] {op_none, op_page_erase, op_block_erase, op_byte_write} fim_op_t;

    // byte that holds a bit address: bit area below 80h, else the 0/8-ending register
    function automatic logic [7:0] fim_bit_byte(input logic [7:0] ba);
        return ba[7] ? {ba[7:3], 3'b000} : (BIT_AREA_BASE | {4'h0, ba[6:3]});
    endfunction

    function automatic logic [15:0] fim_boot_limit(input logic [1:0] sel);
        case (sel)
            2'd1: return BOOT_2K;
            2'd2: return BOOT_4K;
            2'd3: return BOOT_8K;
            default: return 16'h0000;
        endcase
    endfunction
endpackage

// File: rtl/fim_flash_seq.sv
// Purpose: issues page erase, block erase and byte write operations to the flash macro
// Assumes: macro raises flash_busy within one cycle of op_start_ff
// Notes: boot area protection is skipped while the programming port is active
`timescale 1ns/1ps
`default_nettype none
module fim_flash_seq
    import fim_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_val,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [1:0] boot_sel,
    input wire logic icp_active,
    input wire logic flash_busy,
    output fim_op_t op_code_ff,
    output logic op_start_ff,
    output logic [15:0] op_addr_ff,
    output logic [7:0] op_data_ff,
    output logic refused_ff
);
    typedef enum logic {fs_idle, fs_run} fim_fstate_t;
    fim_fstate_t state_ff;
    fim_op_t req_op;
    logic in_boot;
    logic in_data;
    logic bad;

    always_comb begin
        unique case (cmd_val)
            CMD_PAGE_ERASE: req_op = op_page_erase;
            CMD_BLOCK_ERASE: req_op = op_block_erase;
            CMD_BYTE_WRITE: req_op = op_byte_write;
            default: req_op = op_none;
        endcase
    end

    assign in_boot = !icp_active && (addr < fim_boot_limit(boot_sel));
    assign in_data = addr > CODE_LAST;
    // data region takes page erase and byte write only
    assign bad = in_boot || (in_data && req_op == op_block_erase) || state_ff == fs_run;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_start_ff <= 1'b0;
            refused_ff <= 1'b0;
            op_code_ff <= op_none;
            op_addr_ff <= 16'h0000;
            op_data_ff <= 8'h00;
        end else begin
            op_start_ff <= cmd_wr && req_op != op_none && !bad;
            refused_ff <= cmd_wr && req_op != op_none && bad;
            if (cmd_wr && req_op != op_none && !bad) begin
                op_code_ff <= req_op;
                op_addr_ff <= addr;
                op_data_ff <= wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= fs_idle;
        end else begin
            unique case (state_ff)
                fs_idle: if (op_start_ff) state_ff <= fs_run;
                fs_run: if (!flash_busy) state_ff <= fs_idle;
            endcase
        end
    end

    a_boot_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cmd_wr && req_op != op_none && in_boot |=> refused_ff && !op_start_ff)
        else $error("write into protected boot area was not refused");
    a_data_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cmd_wr && req_op == op_block_erase && in_data |=> !op_start_ff)
        else $error("block erase of data region was started");
endmodule
`default_nettype wire

// File: rtl/fim_memmap.sv
// Purpose: internal RAM, special-function registers, external data RAM, display buffer, flash info read
// Assumes: core issues at most one access per cycle; read answers one cycle later
// Notes: rst_n is the power-on reset; other reset sources arrive as rst_event pulses
//
// Contract
// - erased flash bytes read as FFh
// - code and data regions take erase/write ops; data region refuses block erase here
// - boot area of 2, 4 or 8K protected
// - command 88h plus address yields read data
// - secondary window read returns selected contents
// - identity bytes sit at 41A8h to 41AFh
// - 256 internal byte locations, 00h to FFh
// - lower 128 bytes direct and indirect
// - registers at 80h up direct only; bit access at 0/8-ending addresses also reaches them here
// - 4K external data RAM at 0000h-0FFFh
// - display buffer at 1000h-101Bh
// - register pointer takes high byte from A0h
// - addresses ending 0 or 8 bit-accessible
// - power-on reset loads reset cause 02h
// - other resets set only their flag
// - erase time resets DDh, read data 00h
// - secondary index selects the window register
`timescale 1ns/1ps
`default_nettype none
module fim_memmap
    import fim_pkg::*;
#(
    parameter logic [63:0] UID_VALUE = 64'h0123456789ABCDEF // arbitrary identity value
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic acc_req,
    input wire fim_kind_t acc_kind,
    input wire logic acc_we,
    input wire logic [7:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic acc_bit_wdata,
    input wire logic [1:0] reg_bank,
    input wire logic x_req,
    input wire logic x_we,
    input wire logic x_via_ri,
    input wire logic [7:0] x_ri,
    input wire logic [7:0] x_wdata,
    input wire logic [7:0] rst_event,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_blank,
    input wire logic flash_busy,
    input wire logic [1:0] boot_sel,
    input wire logic icp_active,
    output logic [7:0] rd_data_ff,
    output logic rd_valid_ff,
    output logic [7:0] flash_addr_high_ff,
    output logic [7:0] flash_addr_low_ff,
    output logic [7:0] flash_command_ff,
    output logic [7:0] flash_erase_time_ff,
    output fim_op_t flash_op_ff,
    output logic flash_op_start_ff,
    output logic [15:0] flash_op_addr_ff,
    output logic [7:0] flash_op_data_ff,
    output logic flash_refused_ff,
    output logic [DISP_LEN*8-1:0] disp_buf_ff
);
    logic [7:0] iram_ff [256];
    logic [7:0] xram_ff [XRAM_LEN];
    logic [7:0] data_pointer_low_ff;
    logic [7:0] data_pointer_high_ff;
    logic [7:0] secondary_bus_index_ff;
    logic [7:0] paged_xdata_high_byte_ff;
    logic [7:0] flash_write_data_ff;
    logic [7:0] flash_read_data_ff;
    logic [7:0] rst_cause_ff;
    logic first_ff;

    logic sfr_hit;
    logic iram_hit;
    logic x_go;
    logic [7:0] iaddr;
    logic [7:0] sfr_rd;
    logic [7:0] sec_rd;
    logic [7:0] cur;
    logic [7:0] wbyte;
    logic [15:0] xaddr;
    logic in_xram;
    logic in_disp;
    logic [7:0] doff;
    logic [15:0] faddr;
    logic uid_hit;
    logic sfr_wr;
    logic sec_wr;
    logic [7:0] nxt_rst_cause;

    // bit accesses go to the byte that holds them; register-bank accesses use the bank select
    always_comb begin
        unique case (acc_kind)
            k_regn: iaddr = {3'b000, reg_bank, acc_addr[2:0]};
            k_bit: iaddr = fim_bit_byte(acc_addr);
            default: iaddr = acc_addr;
        endcase
    end

    // upper half reaches registers only by direct or bit access
    assign sfr_hit = acc_req && (acc_kind == k_direct || acc_kind == k_bit) && acc_addr[7];
    assign iram_hit = acc_req && !sfr_hit;
    assign sfr_wr = sfr_hit && acc_we;
    assign sec_wr = sfr_wr && iaddr == SFR_SEC_WIN;
    assign x_go = x_req && !acc_req;
    assign xaddr = x_via_ri ? {paged_xdata_high_byte_ff, x_ri}
                            : {data_pointer_high_ff, data_pointer_low_ff};
    assign in_xram = xaddr <= XRAM_LAST;
    assign in_disp = xaddr >= DISP_BASE && xaddr <= DISP_LAST;
    assign doff = {xaddr[4:0], 3'b000};
    assign faddr = {flash_addr_high_ff, flash_addr_low_ff};
    assign uid_hit = faddr >= UID_BASE && faddr <= UID_LAST;

    always_comb begin
        if (secondary_bus_index_ff <= SEC_CFG_LAST) begin
            sec_rd = CFG_WORD_RST;
        end else if (secondary_bus_index_ff == SEC_RST_CAUSE) begin
            sec_rd = rst_cause_ff;
        end else begin
            sec_rd = RST_ZERO;
        end
    end

    always_comb begin
        unique case (iaddr)
            SFR_DPL: sfr_rd = data_pointer_low_ff;
            SFR_DPH: sfr_rd = data_pointer_high_ff;
            SFR_SEC_IDX: sfr_rd = secondary_bus_index_ff;
            SFR_SEC_WIN: sfr_rd = sec_rd;
            SFR_PXH: sfr_rd = paged_xdata_high_byte_ff;
            SFR_FADDR_H: sfr_rd = flash_addr_high_ff;
            SFR_FADDR_L: sfr_rd = flash_addr_low_ff;
            SFR_FWDATA: sfr_rd = flash_write_data_ff;
            SFR_FCMD: sfr_rd = flash_command_ff;
            SFR_FTIME: sfr_rd = flash_erase_time_ff;
            SFR_FRDATA: sfr_rd = flash_read_data_ff;
            default: sfr_rd = RST_ZERO;
        endcase
    end

    // a bit write is a read-modify-write of its byte
    always_comb begin
        cur = sfr_hit ? sfr_rd : iram_ff[iaddr];
        wbyte = acc_wdata;
        if (acc_kind == k_bit) begin
            wbyte = cur;
            wbyte[acc_addr[2:0]] = acc_bit_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (iram_hit && acc_we) begin
            iram_ff[iaddr] <= wbyte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (x_go && x_we && in_xram) begin
            xram_ff[xaddr[11:0]] <= x_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            disp_buf_ff <= '0;
        end else if (x_go && x_we && in_disp) begin
            disp_buf_ff[doff +: 8] <= x_wdata;
        end
    end

    // read-data register is not writable; the read-data address has no entry here
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_pointer_low_ff <= RST_ZERO;
            data_pointer_high_ff <= RST_ZERO;
            secondary_bus_index_ff <= RST_ZERO;
            paged_xdata_high_byte_ff <= RST_PXH;
            flash_addr_high_ff <= RST_ZERO;
            flash_addr_low_ff <= RST_ZERO;
            flash_write_data_ff <= RST_ZERO;
            flash_command_ff <= RST_ZERO;
            flash_erase_time_ff <= RST_FTIME;
        end else if (sfr_wr) begin
            unique case (iaddr)
                SFR_DPL: data_pointer_low_ff <= wbyte;
                SFR_DPH: data_pointer_high_ff <= wbyte;
                SFR_SEC_IDX: secondary_bus_index_ff <= wbyte;
                SFR_PXH: paged_xdata_high_byte_ff <= wbyte;
                SFR_FADDR_H: flash_addr_high_ff <= wbyte;
                SFR_FADDR_L: flash_addr_low_ff <= wbyte;
                SFR_FWDATA: flash_write_data_ff <= wbyte;
                SFR_FCMD: flash_command_ff <= wbyte;
                SFR_FTIME: flash_erase_time_ff <= wbyte;
                default: ;
            endcase
        end
    end

    // reset-cause flags: a source event wins over a software write in the same cycle
    always_comb begin
        nxt_rst_cause = rst_cause_ff;
        if (sec_wr && secondary_bus_index_ff == SEC_RST_CAUSE) begin
            nxt_rst_cause = wbyte;
        end
        nxt_rst_cause = nxt_rst_cause | rst_event;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cause_ff <= RST_CAUSE_POR;
        end else begin
            rst_cause_ff <= nxt_rst_cause;
        end
    end

    // tracks the loaded address every cycle while the info-read command stands
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_read_data_ff <= RST_ZERO;
        end else if (flash_command_ff == CMD_INFO_RD) begin
            if (uid_hit) begin
                flash_read_data_ff <= UID_VALUE[{faddr[2:0], 3'b000} +: 8];
            end else if (flash_blank) begin
                flash_read_data_ff <= ERASED_BYTE;
            end else begin
                flash_read_data_ff <= flash_rdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= RST_ZERO;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= (acc_req && !acc_we) || (x_go && !x_we);
            if (acc_req && !acc_we) begin
                rd_data_ff <= (acc_kind == k_bit) ? {7'h00, cur[acc_addr[2:0]]} : cur;
            end else if (x_go && !x_we) begin
                if (in_xram) begin
                    rd_data_ff <= xram_ff[xaddr[11:0]];
                end else if (in_disp) begin
                    rd_data_ff <= disp_buf_ff[doff +: 8];
                end else begin
                    rd_data_ff <= RST_ZERO;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_ff <= 1'b0;
        end else begin
            first_ff <= 1'b1;
        end
    end

    fim_flash_seq u_seq (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cmd_wr(sfr_wr && iaddr == SFR_FCMD),
        .cmd_val(wbyte),
        .addr(faddr),
        .wdata(flash_write_data_ff),
        .boot_sel(boot_sel),
        .icp_active(icp_active),
        .flash_busy(flash_busy),
        .op_code_ff(flash_op_ff),
        .op_start_ff(flash_op_start_ff),
        .op_addr_ff(flash_op_addr_ff),
        .op_data_ff(flash_op_data_ff),
        .refused_ff(flash_refused_ff)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_xwr;
        x_req && x_we && !acc_req && !x_via_ri && in_xram;
    endsequence
    sequence s_xrd;
        x_req && !x_we && !acc_req && !x_via_ri;
    endsequence

    a_reset_values: assert property (!first_ff |-> paged_xdata_high_byte_ff == RST_PXH
        && flash_erase_time_ff == RST_FTIME && flash_read_data_ff == RST_ZERO && rst_cause_ff == RST_CAUSE_POR)
        else $error("register reset values wrong after release");
    a_cause_sticky: assert property (rst_event != 8'h00 |=> (rst_cause_ff & $past(rst_event)) == $past(rst_event))
        else $error("reset event flag not set");
    a_cause_keep: assert property (rst_event == 8'h00 && !sec_wr |=> $stable(rst_cause_ff))
        else $error("reset cause changed without event");
    a_erased_ones: assert property (flash_command_ff == CMD_INFO_RD && !uid_hit && flash_blank
        |=> flash_read_data_ff == ERASED_BYTE)
        else $error("erased byte not read as all ones");
    a_uid_first: assert property (flash_command_ff == CMD_INFO_RD && faddr == UID_BASE
        |=> flash_read_data_ff == UID_VALUE[7:0])
        else $error("first identity byte wrong");
    a_uid_last: assert property (flash_command_ff == CMD_INFO_RD && faddr == UID_LAST
        |=> flash_read_data_ff == UID_VALUE[63:56])
        else $error("last identity byte wrong");
    a_rdata_follow: assert property (flash_command_ff == CMD_INFO_RD && !uid_hit && !flash_blank
        |=> flash_read_data_ff == $past(flash_rdata))
        else $error("read data does not follow loaded address");
    a_indirect_no_sfr: assert property (acc_req && acc_we && acc_kind == k_indirect && acc_addr == SFR_PXH
        |=> $stable(paged_xdata_high_byte_ff))
        else $error("indirect access reached a register");
    a_xdata_back: assert property (s_xwr ##1 s_xrd |=> rd_data_ff == $past(x_wdata, 2))
        else $error("external data readback mismatch");
    a_disp_write: assert property (x_go && x_we && in_disp |=> disp_buf_ff[$past(doff) +: 8] == $past(x_wdata))
        else $error("display buffer not updated");
    a_bit_area: assert property (acc_req && acc_we && acc_kind == k_bit && !acc_addr[7]
        |=> iram_ff[$past(iaddr)][$past(acc_addr[2:0])] == $past(acc_bit_wdata))
        else $error("bit write did not land in bit area");
    a_sec_window: assert property (acc_req && !acc_we && acc_kind == k_direct && acc_addr == SFR_SEC_WIN
        && secondary_bus_index_ff == SEC_RST_CAUSE |=> rd_data_ff == $past(rst_cause_ff))
        else $error("secondary window returned wrong register");
    a_sec_cfg: assert property (acc_req && !acc_we && acc_kind == k_direct && acc_addr == SFR_SEC_WIN
        && secondary_bus_index_ff <= SEC_CFG_LAST |=> rd_data_ff == CFG_WORD_RST)
        else $error("configuration word did not read as erased");
    a_bit_sfr: assert property (acc_req && acc_we && acc_kind == k_bit
        && acc_addr[7:3] == SFR_PXH[7:3] |=> paged_xdata_high_byte_ff[$past(acc_addr[2:0])] == $past(acc_bit_wdata))
        else $error("bit write to paging register lost");
    a_regn_bank: assert property (acc_req && acc_we && acc_kind == k_regn
        |=> iram_ff[{3'b000, $past(reg_bank), $past(acc_addr[2:0])}] == $past(acc_wdata))
        else $error("working register write went to wrong bank");
    a_rdata_hold: assert property (flash_command_ff != CMD_INFO_RD |=> $stable(flash_read_data_ff))
        else $error("read data changed outside info read");

    // address load under the read command, then a plain byte at the new address
    sequence s_info_load;
        flash_command_ff == CMD_INFO_RD && sfr_wr && (iaddr == SFR_FADDR_H || iaddr == SFR_FADDR_L);
    endsequence
    sequence s_plain_byte;
        flash_command_ff == CMD_INFO_RD && !uid_hit && !flash_blank;
    endsequence
    a_info_load: assert property (s_info_load ##1 s_plain_byte |=> flash_read_data_ff == $past(flash_rdata))
        else $error("read data missed freshly loaded address");
endmodule
`default_nettype wire

// File: test/fim_flash_model.sv
// Purpose: behavioural flash macro behind the info-read port
// Assumes: 2000h-2FFFh erased, other bytes read as high^low
// Notes: busy rises the cycle after a start and holds 3 cycles
`timescale 1ns/1ps
`default_nettype none
module fim_flash_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] addr_h,
    input wire logic [7:0] addr_l,
    input wire logic op_start,
    output logic [7:0] rdata,
    output logic blank,
    output logic busy
);
    logic [1:0] cnt_ff;
    assign blank = (addr_h[7:4] == 4'h2);
    assign rdata = blank ? 8'hFF : (addr_h ^ addr_l);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 2'h0;
        end else if (op_start) begin
            cnt_ff <= 2'h3;
        end else if (cnt_ff != 2'h0) begin
            cnt_ff <= cnt_ff - 2'h1;
        end
    end
    assign busy = (cnt_ff != 2'h0);
endmodule
`default_nettype wire

// File: test/fim_memmap_tb_top.sv
// Purpose: directed bench for the memory map and flash info port
// Assumes: bench acts as the core, one access per call
// Notes: op pulses are looked for over two cycles
`timescale 1ns/1ps
`default_nettype none
module fim_memmap_tb_top
    import fim_pkg::*;
;
    localparam logic [63:0] UID = 64'h18F6E5D4C3B2A170; // arbitrary identity value
    logic ref_clk, rst_n, acc_req, acc_we, acc_bit_wdata, x_req, x_we, x_via_ri;
    logic flash_blank, flash_busy, icp_active, rd_valid_ff, flash_op_start_ff, flash_refused_ff;
    fim_kind_t acc_kind;
    fim_op_t flash_op_ff;
    logic [1:0] reg_bank, boot_sel;
    logic [7:0] acc_addr, acc_wdata, x_ri, x_wdata, rst_event, flash_rdata, rd_data_ff;
    logic [7:0] flash_addr_high_ff, flash_addr_low_ff, flash_command_ff, flash_erase_time_ff;
    logic [7:0] flash_op_data_ff;
    logic [15:0] flash_op_addr_ff;
    logic [DISP_LEN*8-1:0] disp_buf_ff;
    int n_mismatch = 0;
    int cmp_count = 0;
    fim_memmap #(.UID_VALUE(UID)) u_fim_memmap (.ref_clk(ref_clk), .rst_n(rst_n), .acc_req(acc_req),
        .acc_kind(acc_kind), .acc_we(acc_we), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_bit_wdata(acc_bit_wdata), .reg_bank(reg_bank), .x_req(x_req), .x_we(x_we),
        .x_via_ri(x_via_ri), .x_ri(x_ri), .x_wdata(x_wdata), .rst_event(rst_event),
        .flash_rdata(flash_rdata), .flash_blank(flash_blank), .flash_busy(flash_busy),
        .boot_sel(boot_sel), .icp_active(icp_active), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
        .flash_addr_high_ff(flash_addr_high_ff), .flash_addr_low_ff(flash_addr_low_ff),
        .flash_command_ff(flash_command_ff), .flash_erase_time_ff(flash_erase_time_ff),
        .flash_op_ff(flash_op_ff), .flash_op_start_ff(flash_op_start_ff),
        .flash_op_addr_ff(flash_op_addr_ff), .flash_op_data_ff(flash_op_data_ff),
        .flash_refused_ff(flash_refused_ff), .disp_buf_ff(disp_buf_ff));
    fim_flash_model u_fim_flash_model (.ref_clk(ref_clk), .rst_n(rst_n), .addr_h(flash_addr_high_ff),
        .addr_l(flash_addr_low_ff), .op_start(flash_op_start_ff), .rdata(flash_rdata),
        .blank(flash_blank), .busy(flash_busy));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic print_verdict();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input fim_kind_t k, input logic we, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        acc_req = 1'b1;
        acc_kind = k;
        acc_we = we;
        acc_addr = a;
        acc_wdata = d;
        acc_bit_wdata = d[0];
        @(posedge ref_clk);
        #1;
        acc_req = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(k_direct, 1'b1, a, d);
    endtask
    task automatic rd(input fim_kind_t k, input logic [7:0] a, input logic [7:0] e);
        acc(k, 1'b0, a, 8'h00);
        chk(rd_valid_ff, 1'b1);
        chk(rd_data_ff, e);
    endtask
    task automatic xacc(input logic we, input logic ri, input logic [7:0] r, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        x_req = 1'b1;
        x_we = we;
        x_via_ri = ri;
        x_ri = r;
        x_wdata = d;
        @(posedge ref_clk);
        #1;
        x_req = 1'b0;
    endtask
    task automatic xrd(input logic ri, input logic [7:0] r, input logic [7:0] e);
        xacc(1'b0, ri, r, 8'h00);
        chk(rd_valid_ff, 1'b1);
        chk(rd_data_ff, e);
    endtask
    task automatic info(input logic [15:0] a, input logic [7:0] e);
        wr(SFR_FCMD, CMD_INFO_RD);
        wr(SFR_FADDR_H, a[15:8]);
        wr(SFR_FADDR_L, a[7:0]);
        rd(k_direct, SFR_FRDATA, e);
    endtask
    task automatic op_chk(input logic s, input logic r);
        logic gs, gr;
        gs = flash_op_start_ff;
        gr = flash_refused_ff;
        @(posedge ref_clk);
        #1;
        chk(gs | flash_op_start_ff, s);
        chk(gr | flash_refused_ff, r);
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        {rst_n, acc_req, acc_we, acc_bit_wdata, x_req, x_we, x_via_ri, icp_active} = 8'h00;
        {acc_addr, acc_wdata, x_ri, x_wdata, rst_event, reg_bank, boot_sel} = 44'h0;
        acc_kind = k_direct;
        repeat (4) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        chk(flash_erase_time_ff, RST_FTIME);
        rd(k_direct, SFR_FTIME, RST_FTIME);
        wr(SFR_FTIME, 8'hE8);
        chk(flash_erase_time_ff, 8'hE8);
        wr(SFR_FRDATA, 8'h5A);
        rd(k_direct, SFR_FRDATA, 8'h00);
        acc(k_indirect, 1'b1, SFR_PXH, 8'h44);
        rd(k_direct, SFR_PXH, RST_PXH);
        wr(8'h30, 8'h5A);
        rd(k_indirect, 8'h30, 8'h5A);
        acc(k_indirect, 1'b1, SFR_DPL, 8'h33);
        rd(k_direct, SFR_DPL, 8'h00);
        rd(k_indirect, SFR_DPL, 8'h33);
        reg_bank = 2'd2;
        acc(k_regn, 1'b1, 8'h03, 8'hC3);
        rd(k_direct, 8'h13, 8'hC3);
        wr(8'h21, 8'h00);
        acc(k_bit, 1'b1, 8'h0B, 8'h01);
        rd(k_direct, 8'h21, 8'h08);
        acc(k_bit, 1'b0, 8'h0B, 8'h00);
        chk(rd_data_ff[0], 1'b1);
        acc(k_bit, 1'b1, 8'hA7, 8'h00);
        rd(k_direct, SFR_PXH, 8'h7F);
        wr(SFR_DPL, 8'h34);
        wr(SFR_DPH, 8'h0F);
        xacc(1'b1, 1'b0, 8'h00, 8'h9E);
        wr(SFR_PXH, 8'h0F);
        xrd(1'b1, 8'h34, 8'h9E);
        // back-to-back write then read through the data pointer
        @(posedge ref_clk);
        #1;
        {x_req, x_we, x_via_ri, x_wdata} = {3'b110, 8'h5C};
        @(posedge ref_clk);
        #1;
        x_we = 1'b0;
        @(posedge ref_clk);
        #1;
        x_req = 1'b0;
        chk(rd_data_ff, 8'h5C);
        wr(SFR_DPH, 8'h20);
        xacc(1'b1, 1'b0, 8'h00, 8'h11);
        xrd(1'b0, 8'h00, 8'h00);
        wr(SFR_DPH, 8'h10);
        wr(SFR_DPL, 8'h1B);
        xacc(1'b1, 1'b0, 8'h00, 8'h77);
        chk(disp_buf_ff[27*8 +: 8], 8'h77);
        for (int k = 0; k < 8; k++) begin
            info(UID_BASE + 16'(k), UID[8*k +: 8]);
        end
        info(16'h2345, ERASED_BYTE);
        info(16'h3456, 8'h62);
        wr(SFR_FCMD, CMD_IDLE);
        wr(SFR_FADDR_H, 8'h00);
        wr(SFR_FADDR_L, 8'h00);
        chk({flash_command_ff, flash_addr_high_ff | flash_addr_low_ff}, 16'h0);
        rd(k_direct, SFR_FRDATA, 8'h62);
        wr(SFR_SEC_IDX, 8'h05);
        rd(k_direct, SFR_SEC_WIN, CFG_WORD_RST);
        wr(SFR_SEC_IDX, SEC_RST_CAUSE);
        rd(k_direct, SFR_SEC_WIN, RST_CAUSE_POR);
        @(posedge ref_clk);
        #1;
        rst_event = 8'h08;
        @(posedge ref_clk);
        #1;
        rst_event = 8'h00;
        rd(k_direct, SFR_SEC_WIN, 8'h0A);
        wr(SFR_SEC_IDX, 8'h40);
        rd(k_direct, SFR_SEC_WIN, 8'h00);
        boot_sel = 2'd1;
        wr(SFR_FADDR_H, 8'h04);
        wr(SFR_FCMD, CMD_PAGE_ERASE);
        op_chk(1'b0, 1'b1);
        wr(SFR_FADDR_H, 8'h30);
        wr(SFR_FWDATA, 8'hAB);
        wr(SFR_FCMD, CMD_BYTE_WRITE);
        op_chk(1'b1, 1'b0);
        chk(flash_op_addr_ff, 16'h3000);
        chk(flash_op_data_ff, 8'hAB);
        chk(flash_op_ff, op_byte_write);
        wr(SFR_FCMD, CMD_PAGE_ERASE);
        op_chk(1'b0, 1'b1);
        repeat (6) @(posedge ref_clk);
        wr(SFR_FADDR_H, 8'hFC);
        wr(SFR_FCMD, CMD_BLOCK_ERASE);
        op_chk(1'b0, 1'b1);
        icp_active = 1'b1;
        wr(SFR_FADDR_H, 8'h01);
        wr(SFR_FCMD, CMD_BLOCK_ERASE);
        op_chk(1'b1, 1'b0);
        chk(flash_op_ff, op_block_erase);
        print_verdict();
    end
endmodule
`default_nettype wire
